// file: design/pmda_pkg.sv
package pmda_pkg;
    // Pin widths
    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam int WADDR_W = 18;
    localparam int DATA_W = 36;
    localparam int RAS_LANES = 2;
    localparam int CAS_LANES = 4;

    // Clock and times in ns
    localparam int CLK_NS = 100;
    localparam int PAUSE_NS = 100_000;
    localparam int REF_PERIOD_NS = 4_000_000;
    localparam int REF_ROWS = 512;
    localparam int PAGE_ROW_OPEN_MAX_NS = 100_000;

    // Least time rounds up, longest time rounds down
    localparam int PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REF_CYC = REF_PERIOD_NS / REF_ROWS / CLK_NS;
    localparam int PAGE_CYC = PAGE_ROW_OPEN_MAX_NS / CLK_NS;

    // Sequencing counts
    localparam int CAS_CYC = 5;
    localparam int CBR_RAS_CYC = 2;
    localparam int WAKE_CYCLES = 8;
    localparam int PAGE_MARGIN = 12;
    localparam int PAGE_LIMIT = PAGE_CYC - PAGE_MARGIN;

    localparam int CNT_W = 10;
    localparam int OWED_W = 10;
    localparam int WAKE_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [OWED_W-1:0] OWED_LIMIT = 10'h200;
    localparam logic [WAKE_W-1:0] WAKE_INIT = 4'h8;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_PAUSE   = 10'h002,
        ST_RAS_SET = 10'h004,
        ST_ROW     = 10'h008,
        ST_COL_SET = 10'h010,
        ST_COL_STB = 10'h020,
        ST_OPEN    = 10'h040,
        ST_PRE     = 10'h080,
        ST_CBR_CAS = 10'h100,
        ST_CBR_RAS = 10'h200
    } pmda_state_t;
endpackage

// file: design/pmda_sync.sv
`timescale 1ns/1ps
module pmda_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin side
    input wire logic [pmda_pkg::DATA_W-1:0] pin_i,
    // Clean side
    output logic [pmda_pkg::DATA_W-1:0] val_o
);
    import pmda_pkg::*;

    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic v_q;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    v_q <= 1'b0;
                end else begin
                    s1_q <= pin_i[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        v_q <= s3_q;
                    end
                end
            end
            assign val_o[i] = v_q;
        end
    endgenerate
endmodule // pmda_sync

// file: design/pmda_host.sv
`timescale 1ns/1ps
// Function
// - A word address of 18 bits goes out as two 9-bit halves on the shared address pins, row first, column second.
// - Write-select high makes a read and low makes a write, and it is set for every access.
// - A cycle ends with both strobes high, and the row-strobe high time precharges the memory.
// - All 512 rows are strobed within each 4 ms refresh interval by spread refresh cycles.
// - A page burst strobes one row, then pulses the column strobe per column, and ends when the row strobe rises.
// - The row strobe never stays low past 100,000 ns in one page burst.
// - A refresh is CAS-before-RAS from idle: the column strobe falls first, then the row strobe, then both rise.
// - After power-up wait 100 us and run 8 row-strobe cycles, and repeat the 8 whenever 512 refreshes are owed.
module pmda_host (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Request from user
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [pmda_pkg::WADDR_W-1:0] REQ_ADDR,
    input wire logic [pmda_pkg::DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    // Read answer
    output logic RESP_VALID,
    output logic [pmda_pkg::DATA_W-1:0] RESP_RDATA,
    // Memory pins
    output logic [pmda_pkg::ROW_W-1:0] MULTIPLEXED_ADDRESS,
    output logic [pmda_pkg::RAS_LANES-1:0] ROW_STROBE_LANES_N,
    output logic [pmda_pkg::CAS_LANES-1:0] COLUMN_STROBE_LANES_N,
    output logic WRITE_SELECT_N,
    // Data pins, three signals each
    input wire logic [pmda_pkg::DATA_W-1:0] DATA_LINES_I,
    output logic [pmda_pkg::DATA_W-1:0] DATA_LINES_O,
    output logic DATA_LINES_OE_N
);
    import pmda_pkg::*;

    pmda_state_t st_q;
    pmda_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] ref_tick_q;
    logic [CNT_W-1:0] page_cnt_q;
    logic [CNT_W-1:0] gap_q;
    logic [OWED_W-1:0] owed_q;
    logic [WAKE_W-1:0] wake_left_q;
    logic [ROW_W-1:0] row_q;
    logic [COL_W-1:0] col_q;
    logic wr_q;
    logic [DATA_W-1:0] wdata_q;
    logic pend_q;
    logic [DATA_W-1:0] rd_sync;
    logic accept;
    logic same_row;
    logic page_near;
    logic ref_tick;
    logic cbr_done;
    logic ras_low_d;
    logic cas_low_d;

    pmda_sync u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .pin_i(DATA_LINES_I),
        .val_o(rd_sync)
    );

    assign accept = REQ_VALID && REQ_READY;
    assign same_row = (REQ_ADDR[WADDR_W-1:COL_W] == row_q);
    assign page_near = (page_cnt_q >= CNT_W'(PAGE_LIMIT));
    assign ref_tick = (ref_tick_q == CNT_ZERO);
    assign cbr_done = (st_q == ST_CBR_RAS) && (cnt_q == CNT_ZERO);

    // Sequencer next state
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - 1'b1;
        case (st_q)
            ST_PAUSE: begin
                if (cnt_q == CNT_ZERO) begin
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (accept) begin
                    st_d = ST_RAS_SET;
                end else if (wake_left_q != '0 || owed_q != '0) begin
                    st_d = ST_CBR_CAS;
                end
            end
            ST_RAS_SET: st_d = ST_ROW;
            ST_ROW: st_d = ST_COL_SET;
            ST_COL_SET: begin
                st_d = ST_COL_STB;
                cnt_d = CNT_W'(CAS_CYC - 1);
            end
            ST_COL_STB: begin
                if (cnt_q == CNT_ZERO) begin
                    st_d = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (accept) begin
                    st_d = same_row ? ST_COL_SET : ST_PRE;
                end else if (owed_q != '0 || wake_left_q != '0 || page_near) begin
                    st_d = ST_PRE;
                end
            end
            ST_PRE: st_d = pend_q ? ST_RAS_SET : ST_IDLE;
            ST_CBR_CAS: begin
                st_d = ST_CBR_RAS;
                cnt_d = CNT_W'(CBR_RAS_CYC - 1);
            end
            ST_CBR_RAS: begin
                if (cnt_q == CNT_ZERO) begin
                    st_d = ST_PRE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_comb begin
        case (st_d)
            ST_ROW, ST_COL_SET, ST_COL_STB, ST_OPEN, ST_CBR_RAS: ras_low_d = 1'b1;
            default: ras_low_d = 1'b0;
        endcase
        case (st_d)
            ST_COL_STB, ST_CBR_CAS, ST_CBR_RAS: cas_low_d = 1'b1;
            default: cas_low_d = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ST_PAUSE;
            cnt_q <= CNT_W'(PAUSE_CYC - 1);
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Request capture
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            row_q <= '0;
            col_q <= '0;
            wr_q <= 1'b0;
            wdata_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (accept) begin
                row_q <= REQ_ADDR[WADDR_W-1:COL_W];
                col_q <= REQ_ADDR[COL_W-1:0];
                wr_q <= REQ_WRITE;
                wdata_q <= REQ_WDATA;
                pend_q <= (st_q == ST_OPEN) && !same_row;
            end else if (st_q == ST_PRE) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Refresh debt and wake-up
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_tick_q <= CNT_W'(REF_CYC - 1);
            owed_q <= '0;
            wake_left_q <= WAKE_INIT;
        end else begin
            ref_tick_q <= ref_tick ? CNT_W'(REF_CYC - 1) : ref_tick_q - 1'b1;
            if (owed_q == OWED_LIMIT) begin
                owed_q <= '0;
                wake_left_q <= WAKE_INIT;
            end else if (cbr_done && wake_left_q != '0) begin
                wake_left_q <= wake_left_q - 1'b1;
                owed_q <= owed_q + OWED_W'(ref_tick);
            end else if (cbr_done && !ref_tick) begin
                owed_q <= owed_q - 1'b1;
            end else if (!cbr_done && ref_tick) begin
                owed_q <= owed_q + 1'b1;
            end
        end
    end

    // Row-open time of a page burst and time since the last refresh
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            page_cnt_q <= '0;
            gap_q <= '0;
        end else begin
            page_cnt_q <= (ras_low_d && st_d != ST_CBR_RAS) ? page_cnt_q + 1'b1 : CNT_ZERO;
            if (cbr_done) begin
                gap_q <= '0;
            end else if (gap_q != '1) begin
                gap_q <= gap_q + 1'b1;
            end
        end
    end

    // Pin drivers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ROW_STROBE_LANES_N <= '1;
            COLUMN_STROBE_LANES_N <= '1;
            WRITE_SELECT_N <= 1'b1;
            MULTIPLEXED_ADDRESS <= '0;
            DATA_LINES_O <= '0;
            DATA_LINES_OE_N <= 1'b1;
        end else begin
            ROW_STROBE_LANES_N <= {RAS_LANES{!ras_low_d}};
            COLUMN_STROBE_LANES_N <= {CAS_LANES{!cas_low_d}};
            if (st_d == ST_RAS_SET) begin
                MULTIPLEXED_ADDRESS <= accept ? REQ_ADDR[WADDR_W-1:COL_W] : row_q;
            end else if (st_d == ST_COL_SET) begin
                MULTIPLEXED_ADDRESS <= accept ? REQ_ADDR[COL_W-1:0] : col_q;
            end
            if (st_d == ST_COL_SET) begin
                WRITE_SELECT_N <= accept ? !REQ_WRITE : !wr_q;
                DATA_LINES_O <= accept ? REQ_WDATA : wdata_q;
                DATA_LINES_OE_N <= accept ? !REQ_WRITE : !wr_q;
            end else if (st_d != ST_COL_STB) begin
                WRITE_SELECT_N <= 1'b1;
                DATA_LINES_OE_N <= 1'b1;
            end
        end
    end

    // User handshake and read answer
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REQ_READY <= 1'b0;
            RESP_VALID <= 1'b0;
            RESP_RDATA <= '0;
        end else begin
            REQ_READY <= (st_d == ST_IDLE || (st_d == ST_OPEN && !page_near))
                && owed_q == '0 && wake_left_q == '0 && !(accept && st_d == ST_IDLE);
            RESP_VALID <= (st_q == ST_COL_STB) && (cnt_q == CNT_ZERO) && !wr_q;
            if ((st_q == ST_COL_STB) && (cnt_q == CNT_ZERO) && !wr_q) begin
                RESP_RDATA <= rd_sync;
            end
        end
    end

    // Checks
    chk_we_before_cas: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(COLUMN_STROBE_LANES_N[0]) && !ROW_STROBE_LANES_N[0] |-> $stable(WRITE_SELECT_N)
        && DATA_LINES_OE_N == WRITE_SELECT_N)
        else $error("write select or data drive changed with column strobe");
    chk_ras_before_cas: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(COLUMN_STROBE_LANES_N[0]) && !ROW_STROBE_LANES_N[0] |-> $past(ROW_STROBE_LANES_N[0], 2) == 1'b0)
        else $error("column strobe fell without row strobe low first");
    chk_cbr_order: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(COLUMN_STROBE_LANES_N[0]) && ROW_STROBE_LANES_N[0] |=> $fell(ROW_STROBE_LANES_N[0]) ##2
        ROW_STROBE_LANES_N[0] && COLUMN_STROBE_LANES_N[0])
        else $error("refresh strobe order wrong");
    chk_row_addr_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(ROW_STROBE_LANES_N[0]) && COLUMN_STROBE_LANES_N[0] |-> $stable(MULTIPLEXED_ADDRESS)
        && MULTIPLEXED_ADDRESS == row_q)
        else $error("row address not set up at row strobe fall");
    chk_page_open_max: assert property (@(posedge CLK) disable iff (!RST_N)
        page_cnt_q < CNT_W'(PAGE_CYC))
        else $error("row strobe held low too long");
    chk_refresh_gap: assert property (@(posedge CLK) disable iff (!RST_N)
        wake_left_q == '0 && st_q != ST_PAUSE |-> gap_q <= CNT_W'(2 * REF_CYC + PAGE_MARGIN))
        else $error("refresh cycles too far apart");
    chk_cycle_end_high: assert property (@(posedge CLK) disable iff (!RST_N)
        st_q == ST_PRE |-> ROW_STROBE_LANES_N == '1 && COLUMN_STROBE_LANES_N == '1 && DATA_LINES_OE_N)
        else $error("cycle end without both strobes high");
    chk_ready_after_wake: assert property (@(posedge CLK) disable iff (!RST_N)
        REQ_READY |-> wake_left_q == '0 && $past(st_q) != ST_PAUSE)
        else $error("ready before wake-up done");
    chk_read_resp: assert property (@(posedge CLK) disable iff (!RST_N)
        RESP_VALID |-> $past(COLUMN_STROBE_LANES_N[0]) == 1'b0 && $past(WRITE_SELECT_N, CAS_CYC) == 1'b1)
        else $error("read answer without a read column pulse");
    chk_read_floats: assert property (@(posedge CLK) disable iff (!RST_N)
        !COLUMN_STROBE_LANES_N[0] && WRITE_SELECT_N |-> DATA_LINES_OE_N)
        else $error("data driven during a read");
endmodule // pmda_host

// file: sim/pmda_dram_model.sv
`timescale 1ns/1ps
module pmda_dram_model (
    // Strobes and address
    input wire logic [pmda_pkg::RAS_LANES-1:0] ras_n,
    input wire logic [pmda_pkg::CAS_LANES-1:0] cas_n,
    input wire logic we_n,
    input wire logic [pmda_pkg::ROW_W-1:0] addr,
    // Data pins
    input wire logic [pmda_pkg::DATA_W-1:0] din,
    input wire logic oe_n,
    output logic [pmda_pkg::DATA_W-1:0] dout
);
    import pmda_pkg::*;
    logic [DATA_W-1:0] mem [logic [WADDR_W-1:0]];
    logic [ROW_W-1:0] row_q;
    logic [WADDR_W-1:0] a_q;
    int lat = 20;
    int cbr = 0;
    int page_hits = 0;
    int cols = 0;
    int bad = 0;
    realtime t_fall = 0;
    realtime t_rise = 0;
    realtime max_low = 0;
    initial dout = 36'h0;
    always @(negedge ras_n[0]) begin
        if (ras_n !== 2'h0 || $realtime - t_rise < CLK_NS) bad++;
        t_fall = $realtime;
        cols = 0;
        if (cas_n[0] === 1'b0) cbr++;
        else row_q = addr;
    end
    always @(posedge ras_n[0]) begin
        t_rise = $realtime;
        if (t_rise - t_fall > max_low) max_low = t_rise - t_fall;
    end
    // Late write would be a read-write the host never issues
    always @(negedge we_n) if (cas_n[0] === 1'b0) bad++;
    always @(negedge cas_n[0]) begin
        if (cas_n !== 4'h0) bad++;
        if (ras_n[0] === 1'b0) begin
            a_q = {row_q, addr};
            cols++;
            if (cols > 1) page_hits++;
            if (we_n === 1'b0 && oe_n === 1'b0) mem[a_q] = din;
            else if (we_n === 1'b0) bad++;
            else #(lat) dout = mem.exists(a_q) ? mem[a_q] : 36'h0;
        end
    end
    // Released pins show no stale word
    always @(posedge cas_n[0]) dout = ~dout;
endmodule // pmda_dram_model

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pmda_pkg::*;
    logic CLK;
    logic RST_N;
    logic REQ_VALID;
    logic REQ_WRITE;
    logic [WADDR_W-1:0] REQ_ADDR;
    logic [DATA_W-1:0] REQ_WDATA;
    logic REQ_READY;
    logic RESP_VALID;
    logic [DATA_W-1:0] RESP_RDATA;
    logic [ROW_W-1:0] MULTIPLEXED_ADDRESS;
    logic [RAS_LANES-1:0] ROW_STROBE_LANES_N;
    logic [CAS_LANES-1:0] COLUMN_STROBE_LANES_N;
    logic WRITE_SELECT_N;
    logic [DATA_W-1:0] DATA_LINES_I;
    logic [DATA_W-1:0] DATA_LINES_O;
    logic DATA_LINES_OE_N;
    logic [DATA_W-1:0] ref_mem [logic [WADDR_W-1:0]];
    logic [WADDR_W-1:0] q [$];
    int failures = 0;
    int tests_run = 0;
    int c0;

    pmda_host i_dut (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RESP_VALID(RESP_VALID),
        .RESP_RDATA(RESP_RDATA), .MULTIPLEXED_ADDRESS(MULTIPLEXED_ADDRESS),
        .ROW_STROBE_LANES_N(ROW_STROBE_LANES_N), .COLUMN_STROBE_LANES_N(COLUMN_STROBE_LANES_N),
        .WRITE_SELECT_N(WRITE_SELECT_N), .DATA_LINES_I(DATA_LINES_I), .DATA_LINES_O(DATA_LINES_O),
        .DATA_LINES_OE_N(DATA_LINES_OE_N));
    pmda_dram_model i_mem (.ras_n(ROW_STROBE_LANES_N), .cas_n(COLUMN_STROBE_LANES_N), .we_n(WRITE_SELECT_N),
        .addr(MULTIPLEXED_ADDRESS), .din(DATA_LINES_O), .oe_n(DATA_LINES_OE_N), .dout(DATA_LINES_I));

    always #(CLK_NS / 2) CLK = ~CLK;

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        int n;
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        check(36'({ROW_STROBE_LANES_N, COLUMN_STROBE_LANES_N, WRITE_SELECT_N, DATA_LINES_OE_N}), 36'hFF);
        RST_N <= 1'b1;
        c0 = i_mem.cbr;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 3000);
        check(36'(n > PAUSE_CYC && REQ_READY === 1'b1), 36'h1);
        check(36'(i_mem.cbr - c0 >= WAKE_CYCLES), 36'h1);
    endtask

    task automatic access(input logic wr, input logic [WADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        int n;
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= wr;
        REQ_ADDR <= ad;
        REQ_WDATA <= d;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 200);
        REQ_VALID <= 1'b0;
        check(36'(REQ_READY === 1'b1), 36'h1);
        if (wr) begin
            ref_mem[ad] = d;
        end else begin
            n = 0;
            do begin
                @(posedge CLK);
                n++;
            end while (RESP_VALID !== 1'b1 && n < 20);
            check(RESP_RDATA, ref_mem.exists(ad) ? ref_mem[ad] : 36'h0);
            check(36'(n <= 11), 36'h1);
        end
    endtask

    initial begin
        CLK = 1'b0;
        RST_N = 1'b0;
        REQ_VALID = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_ADDR = 18'h00000;
        REQ_WDATA = 36'h0;
        void'($urandom(96));
        do_reset();
        $display("test wakeup done");
        q.push_back(18'h00000);
        q.push_back(18'h3FFFF);
        for (int i = 0; i < 14; i++) q.push_back({7'h00, 2'($urandom), 9'($urandom)});
        foreach (q[i]) access(1'b1, q[i], {4'($urandom), 32'($urandom)});
        for (int i = 0; i < 20; i++) access(1'b0, q[$urandom % q.size()], 36'h0);
        $display("test random done");
        i_mem.lat = 90;
        c0 = i_mem.page_hits;
        for (int i = 0; i < 4; i++) access(1'b1, {9'h1A5, 9'(i * 3)}, {4'($urandom), 32'($urandom)});
        for (int i = 0; i < 4; i++) access(1'b0, {9'h1A5, 9'(i * 3)}, 36'h0);
        check(36'(i_mem.page_hits - c0 >= 4), 36'h1);
        $display("test page done");
        c0 = i_mem.cbr;
        repeat (3000) @(posedge CLK);
        check(36'(i_mem.cbr - c0 >= 3000 / REF_CYC - 1), 36'h1);
        check(36'(i_mem.max_low <= PAGE_ROW_OPEN_MAX_NS), 36'h1);
        $display("test refresh done");
        access(1'b0, q[2], 36'h0);
        do_reset();
        access(1'b0, q[2], 36'h0);
        check(36'(i_mem.bad), 36'h0);
        $display("test reset done");
        end_sim();
    end

    initial begin
        #(20000 * CLK_NS);
        failures++;
        end_sim();
    end
endmodule // testbench
